// ==== ifms_map.vh ====
// register map, field positions, reset values and timing counts
`ifndef IFMS_MAP_VH
`define IFMS_MAP_VH

// register byte offsets
`define IFMS_TERM_SEL0_OFS 8'h00
`define IFMS_TERM_SEL1_OFS 8'h04
`define IFMS_TERM_SEL2_OFS 8'h08
`define IFMS_TERM_SEL3_OFS 8'h0c
`define IFMS_TERM_SEL4_OFS 8'h10
`define IFMS_POLARITY_OFS 8'h14
`define IFMS_UNLOCK_OFS 8'h18
`define IFMS_REMOTE_OFS 8'h1c
`define IFMS_OPMODE_OFS 8'h20
`define IFMS_COMM_OFS 8'h24
`define IFMS_STATUS_OFS 8'h28
`define IFMS_FUNC_OFS 8'h2c

// field positions
`define IFMS_COMM_SHUTOFF_BIT 0
`define IFMS_SEL_W 14
`define IFMS_NTERM 5

// reset values
`define IFMS_SEL0_RST 14'h003c
`define IFMS_SEL1_RST 14'h003d
`define IFMS_SEL2_RST 14'h0000
`define IFMS_SEL3_RST 14'h0001
`define IFMS_SEL4_RST 14'h0002
`define IFMS_POL_RST 3'h0
`define IFMS_UNLOCK_RST 14'h0000
`define IFMS_REMOTE_RST 2'h0
`define IFMS_OPMODE_RST 3'h0

// function codes
`define IFMS_FN_LOW 14'h0000
`define IFMS_FN_MID 14'h0001
`define IFMS_FN_HIGH 14'h0002
`define IFMS_FN_SECOND 14'h0003
`define IFMS_FN_CURSEL 14'h0004
`define IFMS_FN_JOG 14'h0005
`define IFMS_FN_THERMAL 14'h0007
`define IFMS_FN_SPD15 14'h0008
`define IFMS_FN_PERMIT 14'h000a
`define IFMS_FN_INTLK 14'h000c
`define IFMS_FN_PID 14'h000e
`define IFMS_FN_PU_EXT 14'h0010
`define IFMS_FN_SHUTOFF 14'h0018
`define IFMS_FN_HOLD 14'h0019
`define IFMS_FN_FWD 14'h003c
`define IFMS_FN_REV 14'h003d
`define IFMS_FN_CLEAR 14'h003e
`define IFMS_FN_PIDDIR 14'h0040
`define IFMS_FN_PU_NET 14'h0041
`define IFMS_FN_EXT_NET 14'h0042
`define IFMS_FN_CMDSRC 14'h0043
`define IFMS_FN_PIDCLR 14'h0048
`define IFMS_FN_NONE 14'h270f

// polarity and mode values
`define IFMS_POL_NO 3'h0
`define IFMS_POL_NC 3'h2
`define IFMS_POL_SPLIT 3'h4
`define IFMS_OPMODE_INTLK 3'h7

// response limits and clock
`define IFMS_CLK_HZ 10000000
`define IFMS_FAST_RESP_US 2000
`define IFMS_SLOW_RESP_US 20000
`define IFMS_FAST_RESP_CYC (`IFMS_FAST_RESP_US * (`IFMS_CLK_HZ / 1000000))
`define IFMS_SLOW_RESP_CYC (`IFMS_SLOW_RESP_US * (`IFMS_CLK_HZ / 1000000))

// bus responses
`define IFMS_RESP_OKAY 2'h0
`define IFMS_RESP_SLVERR 2'h2

`endif

// ==== ifms_top.v ====
// terminal function mapping and output shutoff with an axi4-lite slave
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "ifms_map.vh"

module ifms_top (
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // contact terminals, 1 = contact closed
    input wire [4:0] term_in,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // start and direction commands
    output reg forward_start,
    output reg reverse_start,
    output reg start_hold_sel,
    output reg drive_clear,
    // speed selection
    output reg low_speed_sel,
    output reg mid_speed_sel,
    output reg high_speed_sel,
    output reg fifteen_speed_ext,
    output reg remote_clear,
    output reg remote_decel,
    output reg remote_accel,
    output reg jog_sel,
    output reg [1:0] speed_source,
    output reg voltage_input_valid,
    output reg current_input_sel,
    output reg second_func_sel,
    // protection and permits
    output reg output_shutoff,
    output reg run_permit,
    output reg panel_interlock,
    output reg ext_thermal_trip,
    // operation mode switchover
    output reg panel_external_switch,
    output reg panel_network_switch,
    output reg external_network_switch,
    output reg command_source_switch,
    // pid control
    output reg pid_enable,
    output reg pid_direction_switch,
    output reg pid_integral_clear
);

    // speed source encoding
    localparam [1:0] SRC_ANALOG = 2'h0;
    localparam [1:0] SRC_JOG = 2'h1;
    localparam [1:0] SRC_MULTI = 2'h2;
    localparam [1:0] SRC_PID = 2'h3;

    // settings
    reg [69:0] sel_r;
    reg [2:0] pol_r;
    reg [13:0] unlock_r;
    reg [1:0] remote_r;
    reg [2:0] opmode_r;
    reg comm_shutoff_r;

    // bus state
    reg [7:0] awaddr_r;
    reg aw_have_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg w_have_r;

    // terminal synchronisers
    reg [4:0] term_meta_r;
    reg [4:0] term_sync_r;

    // legal code for terminal idx; others mean no function
    function legal;
        input [13:0] code;
        input integer idx;
        begin
            case (code)
                14'h0000, 14'h0001, 14'h0002, 14'h0003, 14'h0004,
                14'h0005, 14'h0007, 14'h0008, 14'h000a, 14'h000c,
                14'h000e, 14'h0010, 14'h0018, 14'h0019, 14'h003e,
                14'h0040, 14'h0041, 14'h0042, 14'h0043,
                14'h0048: legal = 1'b1;
                `IFMS_FN_FWD: legal = (idx == 0);
                `IFMS_FN_REV: legal = (idx == 1);
                default: legal = 1'b0;
            endcase
        end
    endfunction

    // or of all terminals carrying one function
    function fn_on;
        input [13:0] code;
        input [69:0] sel;
        input [4:0] lvl;
        integer i;
        begin
            fn_on = 1'b0;
            for (i = 0; i < 5; i = i + 1) begin
                if (sel[i*14 +: 14] == code && legal(code, i))
                    fn_on = fn_on | lvl[i];
            end
        end
    endfunction

    // whether any terminal carries a function
    function fn_used;
        input [13:0] code;
        input [69:0] sel;
        begin
            fn_used = fn_on(code, sel, 5'h1f);
        end
    endfunction

    // byte-lane merge of a write into a stored word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b])
                    merge[b*8 +: 8] = data[b*8 +: 8];
            end
        end
    endfunction

    // two flops ahead of decoding so a mapping never sees a runt
    always @(posedge clk_sys) begin
        if (!nrst) begin
            term_meta_r <= 5'h00;
            term_sync_r <= 5'h00;
        end else begin
            term_meta_r <= term_in;
            term_sync_r <= term_meta_r;
        end
    end

    // decoded terminal functions
    wire ext_shut_on = fn_on(`IFMS_FN_SHUTOFF, sel_r, term_sync_r);
    wire permit_term = fn_on(`IFMS_FN_PERMIT, sel_r, term_sync_r);
    wire intlk_term = fn_on(`IFMS_FN_INTLK, sel_r, term_sync_r);
    wire remote_on = (remote_r != 2'h0);
    wire jog_on = fn_on(`IFMS_FN_JOG, sel_r, term_sync_r);
    wire low_on = fn_on(`IFMS_FN_LOW, sel_r, term_sync_r);
    wire mid_on = fn_on(`IFMS_FN_MID, sel_r, term_sync_r);
    wire high_on = fn_on(`IFMS_FN_HIGH, sel_r, term_sync_r);
    wire spd15_on = fn_on(`IFMS_FN_SPD15, sel_r, term_sync_r);
    wire pid_on = fn_on(`IFMS_FN_PID, sel_r, term_sync_r);
    wire cur_on = fn_on(`IFMS_FN_CURSEL, sel_r, term_sync_r);
    wire multi_on = ~remote_on & (low_on | mid_on | high_on | spd15_on);

    // thermal input counts as on when its contact opens
    wire thermal_on = fn_on(`IFMS_FN_THERMAL, sel_r, ~term_sync_r);

    // polarity table; terminal shutoff acts whatever the mode
    reg shut_nxt;
    always @* begin
        case (pol_r)
            `IFMS_POL_NO: shut_nxt = ext_shut_on | comm_shutoff_r;
            `IFMS_POL_NC:
                shut_nxt = ~(ext_shut_on & comm_shutoff_r);
            `IFMS_POL_SPLIT:
                shut_nxt = ~(ext_shut_on & ~comm_shutoff_r);
            default: shut_nxt = 1'b1; // unreachable values fail safe
        endcase
    end

    // speed source priority
    reg [1:0] src_nxt;
    always @* begin
        if (jog_on)
            src_nxt = SRC_JOG;
        else if (multi_on)
            src_nxt = SRC_MULTI;
        else if (pid_on)
            src_nxt = SRC_PID;
        else
            src_nxt = SRC_ANALOG;
    end

    // all outputs registered; two sync flops plus this one is
    // three cycles, far inside the 2 ms and 20 ms limits
    always @(posedge clk_sys) begin
        if (!nrst) begin
            forward_start <= 1'b0;
            reverse_start <= 1'b0;
            start_hold_sel <= 1'b0;
            drive_clear <= 1'b0;
            low_speed_sel <= 1'b0;
            mid_speed_sel <= 1'b0;
            high_speed_sel <= 1'b0;
            fifteen_speed_ext <= 1'b0;
            remote_clear <= 1'b0;
            remote_decel <= 1'b0;
            remote_accel <= 1'b0;
            jog_sel <= 1'b0;
            speed_source <= SRC_ANALOG;
            voltage_input_valid <= 1'b1;
            current_input_sel <= 1'b0;
            second_func_sel <= 1'b0;
            output_shutoff <= 1'b1;
            run_permit <= 1'b0;
            panel_interlock <= 1'b0;
            ext_thermal_trip <= 1'b0;
            panel_external_switch <= 1'b0;
            panel_network_switch <= 1'b0;
            external_network_switch <= 1'b0;
            command_source_switch <= 1'b0;
            pid_enable <= 1'b0;
            pid_direction_switch <= 1'b0;
            pid_integral_clear <= 1'b0;
        end else begin
            output_shutoff <= shut_nxt;
            // a start is refused while the output is cut
            forward_start <= fn_on(`IFMS_FN_FWD, sel_r, term_sync_r)
                & ~shut_nxt;
            reverse_start <= fn_on(`IFMS_FN_REV, sel_r, term_sync_r)
                & ~shut_nxt;
            start_hold_sel <= fn_on(`IFMS_FN_HOLD, sel_r, term_sync_r);
            drive_clear <= fn_on(`IFMS_FN_CLEAR, sel_r, term_sync_r);
            // shared terminals: multi-speed or remote setting
            low_speed_sel <= low_on & ~remote_on;
            mid_speed_sel <= mid_on & ~remote_on;
            high_speed_sel <= high_on & ~remote_on;
            remote_clear <= low_on & remote_on;
            remote_decel <= mid_on & remote_on;
            remote_accel <= high_on & remote_on;
            fifteen_speed_ext <= spd15_on;
            jog_sel <= jog_on;
            speed_source <= src_nxt;
            current_input_sel <= cur_on;
            voltage_input_valid <= ~cur_on;
            second_func_sel <= fn_on(`IFMS_FN_SECOND, sel_r, term_sync_r);
            ext_thermal_trip <= thermal_on;
            // with no permit terminal the shutoff doubles as permit
            if (fn_used(`IFMS_FN_PERMIT, sel_r))
                run_permit <= permit_term;
            else
                run_permit <= ~shut_nxt;
            if (fn_used(`IFMS_FN_INTLK, sel_r))
                panel_interlock <= intlk_term;
            else if (opmode_r == `IFMS_OPMODE_INTLK)
                panel_interlock <= ~shut_nxt;
            else
                panel_interlock <= 1'b0;
            panel_external_switch <=
                fn_on(`IFMS_FN_PU_EXT, sel_r, term_sync_r);
            panel_network_switch <=
                fn_on(`IFMS_FN_PU_NET, sel_r, term_sync_r);
            external_network_switch <=
                fn_on(`IFMS_FN_EXT_NET, sel_r, term_sync_r);
            command_source_switch <=
                fn_on(`IFMS_FN_CMDSRC, sel_r, term_sync_r);
            pid_enable <= pid_on;
            pid_direction_switch <=
                fn_on(`IFMS_FN_PIDDIR, sel_r, term_sync_r);
            pid_integral_clear <=
                fn_on(`IFMS_FN_PIDCLR, sel_r, term_sync_r);
        end
    end

    // write side: address and data taken in either order
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire do_write = aw_have_r & w_have_r & ~s_axi_bvalid;
    wire [31:0] wmerge = merge(32'h0000_0000, wdata_r, wstrb_r);
    wire unlocked = (unlock_r == 14'h0000);
    wire [2:0] pol_w = wmerge[2:0];
    wire pol_ok = (wmerge[31:3] == 29'h0) && (pol_w == `IFMS_POL_NO ||
        pol_w == `IFMS_POL_NC || pol_w == `IFMS_POL_SPLIT);
    wire [2:0] sel_idx = awaddr_r[4:2];
    wire is_sel = (awaddr_r[7:5] == 3'h0) && (awaddr_r[4:2] < 3'h5);

    // write decode; locked settings or illegal polarity values answer slverr
    reg wr_ok;
    always @* begin
        wr_ok = 1'b1;
        if (awaddr_r[1:0] != 2'h0)
            wr_ok = 1'b0;
        else if (is_sel)
            wr_ok = unlocked;
        else if (awaddr_r == `IFMS_POLARITY_OFS)
            wr_ok = unlocked & pol_ok;
        else if (awaddr_r != `IFMS_UNLOCK_OFS &&
                 awaddr_r != `IFMS_REMOTE_OFS &&
                 awaddr_r != `IFMS_OPMODE_OFS &&
                 awaddr_r != `IFMS_COMM_OFS)
            wr_ok = 1'b0;
    end

    // write channel handshake and register updates
    always @(posedge clk_sys) begin
        if (!nrst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IFMS_RESP_OKAY;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            sel_r <= {`IFMS_SEL4_RST, `IFMS_SEL3_RST, `IFMS_SEL2_RST,
                      `IFMS_SEL1_RST, `IFMS_SEL0_RST};
            pol_r <= `IFMS_POL_RST;
            unlock_r <= `IFMS_UNLOCK_RST;
            remote_r <= `IFMS_REMOTE_RST;
            opmode_r <= `IFMS_OPMODE_RST;
            comm_shutoff_r <= 1'b0;
        end else begin
            if (aw_take) begin
                awaddr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `IFMS_RESP_OKAY : `IFMS_RESP_SLVERR;
                if (wr_ok && is_sel)
                    sel_r[sel_idx*14 +: 14] <= wmerge[13:0];
                if (wr_ok && awaddr_r == `IFMS_POLARITY_OFS)
                    pol_r <= pol_w;
                if (wr_ok && awaddr_r == `IFMS_UNLOCK_OFS)
                    unlock_r <= wmerge[13:0];
                if (wr_ok && awaddr_r == `IFMS_REMOTE_OFS)
                    remote_r <= wmerge[1:0];
                if (wr_ok && awaddr_r == `IFMS_OPMODE_OFS)
                    opmode_r <= wmerge[2:0];
                if (wr_ok && awaddr_r == `IFMS_COMM_OFS)
                    comm_shutoff_r <= wmerge[`IFMS_COMM_SHUTOFF_BIT];
            end
            // reopen both channels only when the response is taken
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // functions currently active, for software to watch
    wire [31:0] func_word = {8'h00, pid_integral_clear,
        pid_direction_switch, pid_enable, command_source_switch,
        external_network_switch, panel_network_switch,
        panel_external_switch, ext_thermal_trip, panel_interlock,
        run_permit, output_shutoff, speed_source, jog_sel,
        remote_accel, remote_decel, remote_clear, high_speed_sel,
        mid_speed_sel, low_speed_sel, drive_clear, start_hold_sel,
        reverse_start, forward_start};

    // read decode
    reg [31:0] rd_nxt;
    reg rd_ok;
    always @* begin
        rd_ok = 1'b1;
        rd_nxt = 32'h0000_0000;
        case (s_axi_araddr)
            `IFMS_TERM_SEL0_OFS: rd_nxt[13:0] = sel_r[13:0];
            `IFMS_TERM_SEL1_OFS: rd_nxt[13:0] = sel_r[27:14];
            `IFMS_TERM_SEL2_OFS: rd_nxt[13:0] = sel_r[41:28];
            `IFMS_TERM_SEL3_OFS: rd_nxt[13:0] = sel_r[55:42];
            `IFMS_TERM_SEL4_OFS: rd_nxt[13:0] = sel_r[69:56];
            `IFMS_POLARITY_OFS: rd_nxt[2:0] = pol_r;
            `IFMS_UNLOCK_OFS: rd_nxt[13:0] = unlock_r;
            `IFMS_REMOTE_OFS: rd_nxt[1:0] = remote_r;
            `IFMS_OPMODE_OFS: rd_nxt[2:0] = opmode_r;
            `IFMS_COMM_OFS: rd_nxt[0] = comm_shutoff_r;
            `IFMS_STATUS_OFS: rd_nxt[4:0] = term_sync_r;
            `IFMS_FUNC_OFS: rd_nxt = func_word;
            default: rd_ok = 1'b0;
        endcase
    end

    // read channel: one read at a time
    always @(posedge clk_sys) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `IFMS_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_nxt;
                s_axi_rresp <= rd_ok ? `IFMS_RESP_OKAY : `IFMS_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // ifms_top

// ==== ifms_chk.sv ====
// assertions on the terminal mapping block ports
`timescale 1ns/1ps
module ifms_chk (
    // clock and reset
    input wire clk_sys, input wire nrst,
    // bus handshake
    input wire s_axi_awvalid, input wire s_axi_awready,
    input wire s_axi_wvalid, input wire s_axi_wready,
    input wire s_axi_bvalid, input wire s_axi_bready,
    input wire [1:0] s_axi_bresp, input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid, input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    // function outputs
    input wire forward_start, input wire reverse_start,
    input wire output_shutoff, input wire voltage_input_valid,
    input wire current_input_sel, input wire jog_sel,
    input wire low_speed_sel, input wire mid_speed_sel,
    input wire high_speed_sel, input wire remote_clear,
    input wire remote_decel, input wire remote_accel,
    input wire [1:0] speed_source
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // both halves of a write taken at the same edge
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wr_answer;
        ##[1:2] s_axi_bvalid;
    endsequence
    // a cut output must never let a start through
    start_gate_a:
        assert property (output_shutoff |-> !forward_start && !reverse_start)
        else $error("start passed while output cut");
    volt_ignore_a:
        assert property (voltage_input_valid == !current_input_sel)
        else $error("voltage input valid with current select");
    remote_excl_a:
        assert property ((remote_clear || remote_decel || remote_accel) |->
            !(low_speed_sel || mid_speed_sel || high_speed_sel))
        else $error("remote and multi-speed both active");
    jog_first_a:
        assert property (jog_sel |-> speed_source == 2'h1)
        else $error("jog not given first place");
    multi_next_a:
        assert property (!jog_sel && (low_speed_sel || mid_speed_sel ||
            high_speed_sel) |-> speed_source == 2'h2)
        else $error("multi-speed not ahead of pid");
    wr_resp_a:
        assert property (wr_take |-> wr_answer)
        else $error("write response missing");
    b_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=>
            s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    r_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
            $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped early");
endmodule // ifms_chk

bind ifms_top ifms_chk u_chk (.*);

// ==== ifms_sw.sv ====
// switch and relay contacts seen at the five terminals
`timescale 1ns/1ps
module ifms_sw (
    // clock
    input wire clk_sys,
    // requested contact state, 1 = closed
    input wire [4:0] contact_req,
    // terminal levels, 1 = contact closed
    output reg [4:0] term_in
);
    // contacts move at an edge; bounce is left out, the syncs would pass it
    initial term_in = 5'h00;
    always @(posedge clk_sys) begin
        term_in <= contact_req;
    end
endmodule // ifms_sw

// ==== tb_input_function_map_and_shutoff.sv ====
// self-checking bench for the terminal function mapping block
`timescale 1ns/1ps
module tb_input_function_map_and_shutoff;
    reg clk_sys = 1'b0, nrst = 1'b0;
    reg [4:0] contact_req = 5'h00;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire [4:0] term_in;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp, speed_source;
    wire [31:0] s_axi_rdata;
    wire forward_start, reverse_start, start_hold_sel, drive_clear;
    wire low_speed_sel, mid_speed_sel, high_speed_sel, fifteen_speed_ext;
    wire remote_clear, remote_decel, remote_accel, jog_sel;
    wire voltage_input_valid, current_input_sel, second_func_sel;
    wire output_shutoff, run_permit, panel_interlock, ext_thermal_trip;
    wire panel_external_switch, panel_network_switch;
    wire external_network_switch, command_source_switch;
    wire pid_enable, pid_direction_switch, pid_integral_clear;
    wire [4:0] dflt_out = {high_speed_sel, mid_speed_sel, low_speed_sel,
        reverse_start, forward_start};
    integer error_cnt = 0, checked = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    logic [13:0] dflt [0:4] = '{14'h3c, 14'h3d, 14'h0, 14'h1, 14'h2};
    logic [13:0] codes [0:17] = '{14'h3, 14'h8, 14'h4, 14'h5, 14'h7,
        14'ha, 14'hc,
        14'he, 14'h10, 14'h19, 14'h3e, 14'h40, 14'h41, 14'h42, 14'h43,
        14'h48, 14'h3c, 14'h270f};
    // {polarity, contact closed, comm command, output cut}
    logic [5:0] rows [0:8] = '{6'h00, 6'h05, 6'h03, 6'h11, 6'h16, 6'h15,
        6'h24, 6'h27, 6'h21};

    ifms_top u_dut (.*);
    ifms_sw u_sw (.clk_sys(clk_sys), .contact_req(contact_req),
        .term_in(term_in));

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("ERROR t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    task conclude;
        begin
            if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask

    // both write channels offered together, each released once taken
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        reg done;
        begin
            done = 1'b0;
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            while (!done) begin
                @(posedge clk_sys);
                if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
                done = s_axi_bvalid;
            end
            s_axi_bready <= 1'b0;
            chk(s_axi_bresp, er);
            @(posedge clk_sys);
        end
    endtask

    task rdr(input [7:0] a);
        reg done;
        begin
            done = 1'b0;
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            while (!done) begin
                @(posedge clk_sys);
                if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
                done = s_axi_rvalid;
            end
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            s_axi_rready <= 1'b0;
            @(posedge clk_sys);
        end
    endtask

    // one edge in the switch model, three through syncs and decode
    task drive(input [4:0] c);
        begin
            contact_req <= c;
            repeat (5) @(posedge clk_sys);
        end
    endtask

    // observed level of the function behind a code; thermal reads inverted
    function logic sig_of(input [13:0] c);
        case (c)
            14'h3: sig_of = second_func_sel;
            14'h8: sig_of = fifteen_speed_ext;
            14'h4: sig_of = current_input_sel;
            14'h5: sig_of = jog_sel;
            14'h7: sig_of = !ext_thermal_trip;
            14'ha: sig_of = run_permit;
            14'hc: sig_of = panel_interlock;
            14'he: sig_of = pid_enable;
            14'h10: sig_of = panel_external_switch;
            14'h19: sig_of = start_hold_sel;
            14'h3e: sig_of = drive_clear;
            14'h40: sig_of = pid_direction_switch;
            14'h41: sig_of = panel_network_switch;
            14'h42: sig_of = external_network_switch;
            14'h43: sig_of = command_source_switch;
            14'h48: sig_of = pid_integral_clear;
            default: sig_of = forward_start | start_hold_sel | pid_enable;
        endcase
    endfunction

    task t_regs;
        integer i;
        begin
            for (i = 0; i < 10; i = i + 1) begin
                rdr(8'(i * 4));
                chk(rd, (i < 5) ? dflt[i] : 14'h0);
            end
            for (i = 0; i < 5; i = i + 1) begin
                drive(5'h01 << i);
                chk(dflt_out, 5'h01 << i);
            end
            rdr(8'h2c);
            chk(rd, 32'h5040);
        end
    endtask

    task t_codes;
        integer i;
        logic e;
        begin
            for (i = 0; i < 18; i = i + 1) begin
                e = (codes[i] != 14'h3c) && (codes[i] != 14'h270f);
                wr(8'h10, codes[i], 2'h0);
                drive(5'h10);
                chk(sig_of(codes[i]), e);
                drive(5'h00);
                chk(sig_of(codes[i]), 1'b0);
            end
            wr(8'h0c, 32'he, 2'h0);
            wr(8'h10, 32'he, 2'h0);
            drive(5'h08);
            chk(speed_source, 2'h3);
            drive(5'h10);
            chk(pid_enable, 1'b1);
            drive(5'h14);
            chk(speed_source, 2'h2);
            wr(8'h0c, 32'h1, 2'h0);
            wr(8'h10, 32'h2, 2'h0);
            wr(8'h1c, 32'h1, 2'h0);
            drive(5'h1c);
            chk({remote_accel, remote_decel, remote_clear}, 3'h7);
            chk(dflt_out, 5'h00);
            wr(8'h1c, 32'h0, 2'h0);
        end
    endtask

    task t_shut;
        integer i;
        begin
            wr(8'h10, 32'h18, 2'h0);
            for (i = 0; i < 9; i = i + 1) begin
                wr(8'h14, rows[i][5:3], 2'h0);
                wr(8'h24, rows[i][1], 2'h0);
                drive({rows[i][2], 4'h1});
                chk(output_shutoff, rows[i][0]);
                chk(forward_start, !rows[i][0]);
                chk(run_permit, !rows[i][0]);
            end
            wr(8'h14, 32'h3, 2'h2);
            wr(8'h14, 32'h0, 2'h0);
            wr(8'h24, 32'h0, 2'h0);
            wr(8'h20, 32'h7, 2'h0);
            drive(5'h11);
            chk(output_shutoff, 1'b1);
            chk(panel_interlock, 1'b0);
            drive(5'h01);
            chk(panel_interlock, 1'b1);
            wr(8'h20, 32'h0, 2'h0);
            wr(8'h10, 32'h2, 2'h0);
            drive(5'h00);
        end
    endtask

    // settings locked, then unmapped and read-only places
    task t_lock;
        begin
            wr(8'h18, 32'h1, 2'h0);
            wr(8'h10, 32'he, 2'h2);
            wr(8'h14, 32'h2, 2'h2);
            rdr(8'h10);
            chk(rd, 32'h2);
            wr(8'h18, 32'h0, 2'h0);
            wr(8'h30, 32'h1, 2'h2);
            wr(8'h28, 32'h1, 2'h2);
            rdr(8'h30);
            chk(rs, 2'h2);
        end
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        t_regs;
        t_codes;
        t_shut;
        t_lock;
        conclude;
    end

    // cut a hang short well past the expected run length
    initial begin
        repeat (30000) @(posedge clk_sys);
        error_cnt = error_cnt + 1;
        conclude;
    end
endmodule // tb_input_function_map_and_shutoff
